/* touch_acq_pkg.sv */
// Constants and types shared by the touch acquisition control block
package touch_acq_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ACQ_SELECT = 8'h50;
  localparam logic [7:0] OFS_ACQ_COUNT = 8'h54;
  localparam logic [7:0] OFS_BURST_LENGTHS = 8'h58;
  localparam logic [7:0] OFS_DISCHARGE = 8'h5c;
  localparam logic [7:0] OFS_SPREAD = 8'h60;
  localparam logic [7:0] OFS_PAD_A_RES = 8'h64;
  localparam logic [7:0] OFS_PAD_B_RES = 8'h68;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int COUNT_LSB = 0;
  localparam int INDEX_LSB = 16;
  localparam int YIDX_LSB = 24;
  localparam int FORCE_LSB = 24;
  localparam int CURRENT_MODULE_ON_BIT = 23;
  localparam int VREF_BIT = 17;
  localparam int RSEL_BIT = 16;
  localparam int TRIM_LSB = 8;
  localparam int TRIM_W = 5;
  localparam int SRC_LSB = 0;
  localparam int PAD_W = 17;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] RST_ACQ_SELECT = 2'h0;
  localparam logic [31:0] RST_ACQ_COUNT = 32'h0000_0000;
  localparam logic [31:0] RST_DISCHARGE = 32'h0000_0000;
  localparam logic [7:0] RST_SPREAD = 8'h00;
  localparam logic [16:0] RST_PAD_RES = 17'h0_0000;

  // ----------------------------------------
  // Burst timing
  // ----------------------------------------
  localparam int PRESCALE_DIV = 4;
  localparam int BASE_PULSE_TICKS = 16;

  typedef enum logic [1:0] {
    ACQ_SELF_A = 2'b00,
    ACQ_SELF_B = 2'b01,
    ACQ_MATRIX = 2'b10,
    ACQ_UNDEF = 2'b11
  } acq_type_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_NEED_BLEN = 3'b001,
    ST_BURST = 3'b010,
    ST_MEASURE = 3'b011,
    ST_HOLD = 3'b100
  } eng_state_t;

endpackage

/* burst_pulser.sv */
// Burst pulse train generator with spread-spectrum pulse length
`timescale 1ns/1ps
module burst_pulser #(
  parameter int PRESCALE = touch_acq_pkg::PRESCALE_DIV,
  parameter int BASE = touch_acq_pkg::BASE_PULSE_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] reps_i,
  input wire logic spread_on_i,
  input wire logic [7:0] max_shift_i,
  output logic drive_o,
  output logic burst_phase_o,
  output logic done_o
);

  logic [7:0] pre_cnt, next_pre_cnt;
  logic [9:0] tick_cnt, next_tick_cnt;
  logic [9:0] cur_len, next_cur_len;
  logic [7:0] reps_left, next_reps_left;
  logic [8:0] lfsr, next_lfsr;
  logic next_drive, next_phase, next_done;
  logic [15:0] hi_run;

  // Pulse length deviated by at most the spread setting, never below one tick
  function automatic logic [9:0] shaped_len(input logic [8:0] rnd, input logic [7:0] max_dev,
                                           input logic on);
    logic [9:0] mag;
    mag = (rnd[7:0] > max_dev) ? {2'h0, max_dev} : {2'h0, rnd[7:0]};
    if (!on) begin
      shaped_len = 10'(BASE);
    end else if (rnd[8]) begin
      shaped_len = 10'(BASE) + mag;
    end else if (mag >= 10'(BASE)) begin
      shaped_len = 10'h001;
    end else begin
      shaped_len = 10'(BASE) - mag;
    end
  endfunction

  always_comb begin
    next_pre_cnt = pre_cnt;
    next_tick_cnt = tick_cnt;
    next_cur_len = cur_len;
    next_reps_left = reps_left;
    next_lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
    next_drive = drive_o;
    next_phase = burst_phase_o;
    next_done = 1'b0;
    if (start_i) begin
      next_pre_cnt = 8'h00;
      next_tick_cnt = 10'h000;
      next_reps_left = reps_i;
      next_cur_len = shaped_len(lfsr, max_shift_i, spread_on_i);
      next_phase = (reps_i != 8'h00);
      next_drive = (reps_i != 8'h00);
      next_done = (reps_i == 8'h00);
    end else if (burst_phase_o) begin
      if (pre_cnt == 8'(PRESCALE - 1)) begin
        next_pre_cnt = 8'h00;
        if (tick_cnt + 10'h001 >= cur_len) begin
          next_tick_cnt = 10'h000;
          if (drive_o) begin
            next_drive = 1'b0;
          end else if (reps_left == 8'h01) begin
            next_phase = 1'b0;
            next_done = 1'b1;
          end else begin
            next_reps_left = reps_left - 8'h01;
            next_drive = 1'b1;
            next_cur_len = shaped_len(lfsr, max_shift_i, spread_on_i);
          end
        end else begin
          next_tick_cnt = tick_cnt + 10'h001;
        end
      end else begin
        next_pre_cnt = pre_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_cnt <= 8'h00;
      tick_cnt <= 10'h000;
      cur_len <= 10'h001;
      reps_left <= 8'h00;
      lfsr <= 9'h1a5;
      drive_o <= 1'b0;
      burst_phase_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      tick_cnt <= next_tick_cnt;
      cur_len <= next_cur_len;
      reps_left <= next_reps_left;
      lfsr <= next_lfsr;
      drive_o <= next_drive;
      burst_phase_o <= next_phase;
      done_o <= next_done;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !drive_o) begin
      hi_run <= 16'h0000;
    end else begin
      hi_run <= hi_run + 16'h0001;
    end
  end

  AST_PULSE_DEVIATION: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (drive_o && !next_drive && spread_on_i) |->
      (32'(hi_run) + 1 <= (BASE + 32'(max_shift_i)) * PRESCALE))
    else $error("Burst pulse longer than base plus deviation");

endmodule

/* cap_touch_acquisition_ctrl.sv */
// Register-controlled capacitive touch acquisition sequencer
`timescale 1ns/1ps
module cap_touch_acquisition_ctrl #(
  parameter int NUM_PAIRS = 17,
  parameter int NUM_X = 8,
  parameter int NUM_Y = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [NUM_PAIRS-1:0] pair_en_a_i,
  input wire logic [NUM_PAIRS-1:0] pair_en_b_i,
  input wire logic [NUM_X-1:0] x_en_i,
  input wire logic [NUM_Y-1:0] y_en_i,
  input wire logic [7:0] self_burst_len_i,
  input wire logic spread_on_i,
  input wire logic meas_valid_i,
  input wire logic [15:0] meas_count_i,
  output logic meas_active_o,
  output logic [7:0] pair_or_column_index_o,
  output logic [7:0] meas_y_o,
  output logic burst_drive_o,
  output logic burst_values_needed_o,
  output logic count_data_avail_o,
  output logic acq_busy_o,
  output logic [7:0] discharge_src_en_o,
  output logic current_module_on_o,
  output logic ref_voltage_choice_o,
  output logic ref_resistor_choice_o,
  output logic [4:0] trim_o,
  output logic [16:0] ohmic_drive_a_o,
  output logic [16:0] ohmic_drive_b_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Returns {found, index} of the first set bit above a start point, or at it when incl is set
  function automatic logic [8:0] next_set(input logic [31:0] mask, input logic [7:0] from,
                                          input logic incl);
    logic hit;
    logic [7:0] idx;
    hit = 1'b0;
    idx = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (!hit && mask[i] && ((8'(i) > from) || (incl && (8'(i) == from)))) begin
        hit = 1'b1;
        idx = 8'(i);
      end
    end
    next_set = {hit, idx};
  endfunction

  function automatic logic [7:0] ones(input logic [31:0] mask);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {7'h00, mask[i]};
    end
    ones = n;
  endfunction

  logic [31:0] mask_a, mask_b, mask_x, mask_y;
  logic [7:0] y_total;
  logic wr_sel, wr_blen, rd_count;

  assign mask_a = 32'(pair_en_a_i);
  assign mask_b = 32'(pair_en_b_i);
  assign mask_x = 32'(x_en_i);
  assign mask_y = 32'(y_en_i);
  assign y_total = ones(mask_y);
  assign wr_sel = wr_i && (addr_i == touch_acq_pkg::OFS_ACQ_SELECT);
  assign wr_blen = wr_i && (addr_i == touch_acq_pkg::OFS_BURST_LENGTHS);
  assign rd_count = rd_i && (addr_i == touch_acq_pkg::OFS_ACQ_COUNT);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [1:0] acq_sel, next_acq_sel;
  logic [31:0] discharge_source_control, next_discharge_source_control;
  logic [7:0] spread_max_shift, next_spread_max_shift;
  logic [16:0] pad_a_res, next_pad_a_res, pad_b_res, next_pad_b_res;

  always_comb begin
    next_acq_sel = acq_sel;
    next_discharge_source_control = discharge_source_control;
    next_spread_max_shift = spread_max_shift;
    next_pad_a_res = pad_a_res;
    next_pad_b_res = pad_b_res;
    if (wr_i) begin
      case (addr_i)
        touch_acq_pkg::OFS_ACQ_SELECT: next_acq_sel = wdata_i[1:0];
        touch_acq_pkg::OFS_DISCHARGE: next_discharge_source_control = wdata_i & 32'hff83_1fff;
        touch_acq_pkg::OFS_SPREAD: next_spread_max_shift = wdata_i[7:0];
        touch_acq_pkg::OFS_PAD_A_RES: next_pad_a_res = wdata_i[16:0];
        touch_acq_pkg::OFS_PAD_B_RES: next_pad_b_res = wdata_i[16:0];
        default: next_acq_sel = acq_sel;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      acq_sel <= touch_acq_pkg::RST_ACQ_SELECT;
      discharge_source_control <= touch_acq_pkg::RST_DISCHARGE;
      spread_max_shift <= touch_acq_pkg::RST_SPREAD;
      pad_a_res <= touch_acq_pkg::RST_PAD_RES;
      pad_b_res <= touch_acq_pkg::RST_PAD_RES;
    end else begin
      acq_sel <= next_acq_sel;
      discharge_source_control <= next_discharge_source_control;
      spread_max_shift <= next_spread_max_shift;
      pad_a_res <= next_pad_a_res;
      pad_b_res <= next_pad_b_res;
    end
  end

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  touch_acq_pkg::eng_state_t state, next_state;
  touch_acq_pkg::acq_type_t acq_type, next_acq_type;
  logic [7:0] cur_x, next_cur_x, cur_y, next_cur_y;
  logic [7:0] y_slot, next_y_slot, fill, next_fill;
  logic [7:0] burst_mem [NUM_Y];
  logic [7:0] next_burst_mem [NUM_Y];
  logic [31:0] result, next_result;
  logic avail, next_avail, pulse_start, next_pulse_start;
  logic pulse_done, burst_phase;
  logic [8:0] first_pair, first_x, first_y, step_pair, step_x, step_y;
  logic [31:0] self_mask;

  assign self_mask = (acq_type == touch_acq_pkg::ACQ_SELF_B) ? mask_b : mask_a;
  assign step_pair = next_set(self_mask, cur_x, 1'b0);
  assign step_y = next_set(mask_y, cur_y, 1'b0);
  assign step_x = next_set(mask_x, cur_x, 1'b0);
  assign first_x = next_set(mask_x, 8'h00, 1'b1);
  assign first_y = next_set(mask_y, 8'h00, 1'b1);
  assign first_pair = next_set((wdata_i[1:0] == touch_acq_pkg::ACQ_SELF_B) ? mask_b : mask_a,
                               8'h00, 1'b1);

  always_comb begin
    next_state = state;
    next_acq_type = acq_type;
    next_cur_x = cur_x;
    next_cur_y = cur_y;
    next_y_slot = y_slot;
    next_fill = fill;
    next_burst_mem = burst_mem;
    next_result = result;
    next_avail = avail;
    next_pulse_start = 1'b0;
    if (rd_count) begin
      next_avail = 1'b0;
    end
    if (wr_blen && (state == touch_acq_pkg::ST_NEED_BLEN) && (fill < y_total)) begin
      for (int k = 0; k < 4; k++) begin
        if (32'(fill) + k < NUM_Y) begin
          next_burst_mem[32'(fill) + k] = wdata_i[31 - 8 * k -: 8];
        end
      end
      next_fill = fill + 8'h04;
    end
    case (state)
      touch_acq_pkg::ST_IDLE: begin
        next_state = touch_acq_pkg::ST_IDLE;
      end
      touch_acq_pkg::ST_NEED_BLEN: begin
        if (fill >= y_total) begin
          next_state = touch_acq_pkg::ST_BURST;
          next_pulse_start = 1'b1;
        end
      end
      touch_acq_pkg::ST_BURST: begin
        if (pulse_done) begin
          next_state = touch_acq_pkg::ST_MEASURE;
        end
      end
      touch_acq_pkg::ST_MEASURE: begin
        if (meas_valid_i) begin
          next_result = {cur_y, cur_x, meas_count_i};
          next_avail = 1'b1;
          next_state = touch_acq_pkg::ST_HOLD;
        end
      end
      touch_acq_pkg::ST_HOLD: begin
        if (!avail) begin
          next_state = touch_acq_pkg::ST_IDLE;
          if (acq_type != touch_acq_pkg::ACQ_MATRIX) begin
            if (step_pair[8]) begin
              next_cur_x = step_pair[7:0];
              next_state = touch_acq_pkg::ST_BURST;
              next_pulse_start = 1'b1;
            end
          end else if (step_y[8]) begin
            next_cur_y = step_y[7:0];
            next_y_slot = y_slot + 8'h01;
            next_state = touch_acq_pkg::ST_BURST;
            next_pulse_start = 1'b1;
          end else if (step_x[8]) begin
            next_cur_x = step_x[7:0];
            next_cur_y = first_y[7:0];
            next_y_slot = 8'h00;
            next_fill = 8'h00;
            next_state = touch_acq_pkg::ST_NEED_BLEN;
          end
        end
      end
      default: next_state = touch_acq_pkg::ST_IDLE;
    endcase
    if (wr_sel) begin
      next_acq_type = touch_acq_pkg::acq_type_t'(wdata_i[1:0]);
      next_cur_y = 8'h00;
      next_y_slot = 8'h00;
      next_fill = 8'h00;
      next_state = touch_acq_pkg::ST_IDLE;
      if (wdata_i[1:0] == touch_acq_pkg::ACQ_MATRIX) begin
        if (first_x[8] && first_y[8]) begin
          next_cur_x = first_x[7:0];
          next_cur_y = first_y[7:0];
          next_state = touch_acq_pkg::ST_NEED_BLEN;
        end
      end else if (wdata_i[1:0] != touch_acq_pkg::ACQ_UNDEF && first_pair[8]) begin
        next_cur_x = first_pair[7:0];
        next_state = touch_acq_pkg::ST_BURST;
        next_pulse_start = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= touch_acq_pkg::ST_IDLE;
      acq_type <= touch_acq_pkg::ACQ_SELF_A;
      cur_x <= 8'h00;
      cur_y <= 8'h00;
      y_slot <= 8'h00;
      fill <= 8'h00;
      result <= touch_acq_pkg::RST_ACQ_COUNT;
      avail <= 1'b0;
      pulse_start <= 1'b0;
      for (int i = 0; i < NUM_Y; i++) begin
        burst_mem[i] <= 8'h00;
      end
    end else begin
      state <= next_state;
      acq_type <= next_acq_type;
      cur_x <= next_cur_x;
      cur_y <= next_cur_y;
      y_slot <= next_y_slot;
      fill <= next_fill;
      result <= next_result;
      avail <= next_avail;
      pulse_start <= next_pulse_start;
      burst_mem <= next_burst_mem;
    end
  end

  burst_pulser u_pulser (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(pulse_start),
    .reps_i((acq_type == touch_acq_pkg::ACQ_MATRIX) ? burst_mem[y_slot[2:0]] :
            self_burst_len_i),
    .spread_on_i(spread_on_i),
    .max_shift_i(spread_max_shift),
    .drive_o(burst_drive_o),
    .burst_phase_o(burst_phase),
    .done_o(pulse_done)
  );

  // ----------------------------------------
  // Read port and outputs
  // ----------------------------------------
  logic [31:0] next_rdata;
  logic [7:0] next_dis;
  logic next_needed, next_meas, next_busy;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        touch_acq_pkg::OFS_ACQ_SELECT: next_rdata = {30'h0, acq_sel};
        touch_acq_pkg::OFS_ACQ_COUNT: next_rdata = result;
        touch_acq_pkg::OFS_DISCHARGE: next_rdata = discharge_source_control;
        touch_acq_pkg::OFS_SPREAD: next_rdata = {24'h0, spread_max_shift};
        touch_acq_pkg::OFS_PAD_A_RES: next_rdata = {15'h0, pad_a_res};
        touch_acq_pkg::OFS_PAD_B_RES: next_rdata = {15'h0, pad_b_res};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_meas = (next_state == touch_acq_pkg::ST_MEASURE);
    next_busy = (next_state != touch_acq_pkg::ST_IDLE);
    next_dis = 8'h00;
    if (discharge_source_control[touch_acq_pkg::CURRENT_MODULE_ON_BIT]) begin
      next_dis = discharge_source_control[touch_acq_pkg::FORCE_LSB +: 8] |
                 (discharge_source_control[touch_acq_pkg::SRC_LSB +: 8] & {8{next_meas}});
    end
    next_needed = (next_state == touch_acq_pkg::ST_NEED_BLEN) && (next_fill < y_total);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
      discharge_src_en_o <= 8'h00;
      burst_values_needed_o <= 1'b0;
      meas_active_o <= 1'b0;
      acq_busy_o <= 1'b0;
      ohmic_drive_a_o <= 17'h0_0000;
      ohmic_drive_b_o <= 17'h0_0000;
    end else begin
      rdata_o <= next_rdata;
      discharge_src_en_o <= next_dis;
      burst_values_needed_o <= next_needed;
      meas_active_o <= next_meas;
      acq_busy_o <= next_busy;
      ohmic_drive_a_o <= pad_a_res & {touch_acq_pkg::PAD_W{burst_phase}};
      ohmic_drive_b_o <= pad_b_res & {touch_acq_pkg::PAD_W{burst_phase}};
    end
  end

  assign count_data_avail_o = avail;
  assign pair_or_column_index_o = cur_x;
  assign meas_y_o = cur_y;
  assign current_module_on_o = discharge_source_control[touch_acq_pkg::CURRENT_MODULE_ON_BIT];
  assign ref_voltage_choice_o = discharge_source_control[touch_acq_pkg::VREF_BIT];
  assign ref_resistor_choice_o = discharge_source_control[touch_acq_pkg::RSEL_BIT];
  assign trim_o = discharge_source_control[touch_acq_pkg::TRIM_LSB +: touch_acq_pkg::TRIM_W];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SELECT_STARTS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_sel && wdata_i[1:0] == touch_acq_pkg::ACQ_SELF_A && pair_en_a_i != '0) |=>
      (state == touch_acq_pkg::ST_BURST) ##1 burst_phase)
    else $error("Selection write did not start a burst");

  AST_SELECT_READBACK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_sel ##1 !wr_sel ##1 (rd_i && addr_i == touch_acq_pkg::OFS_ACQ_SELECT)) |=>
      (rdata_o == {30'h0, $past(wdata_i[1:0], 3)}))
    else $error("Selection readback differs from last write");

  AST_COUNT_READ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_count |=> (rdata_o == $past(result)))
    else $error("Count read returned wrong word");

  AST_SELF_Y_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($rose(avail) && acq_type != touch_acq_pkg::ACQ_MATRIX) |-> (result[31:24] == 8'h00))
    else $error("Self-capacitance result with nonzero Y");

  AST_NEED_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state == touch_acq_pkg::ST_NEED_BLEN && fill < y_total) |-> burst_values_needed_o)
    else $error("Burst values needed flag low while waiting");

  AST_GLOBAL_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !discharge_source_control[touch_acq_pkg::CURRENT_MODULE_ON_BIT] |=> (discharge_src_en_o == 8'h00))
    else $error("Discharge source on while module disabled");

  AST_FORCE_ON: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (discharge_source_control[touch_acq_pkg::CURRENT_MODULE_ON_BIT] && $stable(discharge_source_control)) |=>
      ((discharge_src_en_o & $past(discharge_source_control[31:24])) == $past(discharge_source_control[31:24])))
    else $error("Forced discharge source not on");

  AST_SOURCE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state != touch_acq_pkg::ST_MEASURE && next_state != touch_acq_pkg::ST_MEASURE) |=>
      (discharge_src_en_o == $past(discharge_source_control[31:24] & {8{discharge_source_control[23]}})))
    else $error("Discharge source on outside measurement");

  AST_CONSUME: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_count && avail) |=> !avail)
    else $error("Count read did not consume the result");

  AST_IGNORE_BLEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_blen && !burst_values_needed_o && !wr_sel && state != touch_acq_pkg::ST_HOLD) |=>
      $stable(fill))
    else $error("Burst write accepted without request");

  AST_PAD_OHMIC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !$past(burst_phase) |-> (ohmic_drive_a_o == 17'h0_0000 && ohmic_drive_b_o == 17'h0_0000))
    else $error("Resistive drive outside burst phase");

endmodule

/* touch_front_model.sv */
// Behavioural sensor front end answering each measurement phase
`timescale 1ns/1ps
module touch_front_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic meas_active_i,
  input wire logic [7:0] idx_i,
  input wire logic [7:0] y_i,
  input wire logic [7:0] delay_i,
  output logic meas_valid_o,
  output logic [15:0] meas_count_o
);
  logic [7:0] wait_cnt = 8'h00;
  logic sent = 1'b0;
  initial begin
    meas_valid_o = 1'b0;
    meas_count_o = 16'h0000;
  end
  // Count lines toggle outside a delivery
  always @(posedge ref_clk_i) begin
    meas_valid_o <= 1'b0;
    meas_count_o <= ~meas_count_o;
    if (rst_i || !meas_active_i) begin
      wait_cnt <= 8'h00;
      sent <= 1'b0;
    end else if (!sent && wait_cnt == delay_i) begin
      meas_valid_o <= 1'b1;
      meas_count_o <= {idx_i, y_i};
      sent <= 1'b1;
    end else if (!sent) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the touch acquisition control block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [16:0] pair_en_a_i = 17'h0_0212;
  logic [16:0] pair_en_b_i = 17'h1_0001;
  logic [7:0] x_en_i = 8'h0c;
  logic [7:0] y_en_i = 8'h90;
  logic [7:0] self_burst_len_i = 8'h01;
  logic spread_on_i = 1'b1;
  logic [7:0] delay_i = 8'h00;
  logic [31:0] rdata_o;
  logic [15:0] meas_count_i;
  logic [7:0] pair_or_column_index_o, meas_y_o, discharge_src_en_o;
  logic meas_valid_i, meas_active_o, burst_drive_o, burst_values_needed_o, count_data_avail_o;
  logic acq_busy_o, current_module_on_o, ref_voltage_choice_o, ref_resistor_choice_o;
  logic [4:0] trim_o;
  logic [16:0] ohmic_drive_a_o, ohmic_drive_b_o;
  int err_total = 0;
  int n_tests = 0;
  cap_touch_acquisition_ctrl uut (
    .ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pair_en_a_i,
    .pair_en_b_i, .x_en_i, .y_en_i, .self_burst_len_i, .spread_on_i, .meas_valid_i,
    .meas_count_i, .meas_active_o, .pair_or_column_index_o, .meas_y_o, .burst_drive_o,
    .burst_values_needed_o, .count_data_avail_o, .acq_busy_o, .discharge_src_en_o,
    .current_module_on_o, .ref_voltage_choice_o, .ref_resistor_choice_o, .trim_o,
    .ohmic_drive_a_o, .ohmic_drive_b_o
  );
  touch_front_model front (
    .ref_clk_i, .rst_i, .meas_active_i(meas_active_o), .idx_i(pair_or_column_index_o),
    .y_i(meas_y_o), .delay_i, .meas_valid_o(meas_valid_i), .meas_count_o(meas_count_i)
  );
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, rdata_o, exp);
  endtask
  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge ref_clk_i);
      #1;
      if ((sel == 1 ? burst_values_needed_o : sel == 2 ? burst_drive_o :
           sel == 3 ? meas_active_o : count_data_avail_o) === 1'b1) return;
    end
    err_total++;
    final_report();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    int g, p, x, y;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (p = 8'h50; p <= 8'h70; p += 4)
      rdc(p[7:0], 32'h0, "reset value");
    wr(8'h5c, 32'hffff_ffff);
    rdc(8'h5c, 32'hff83_1fff, "discharge");
    chk("module on", {31'h0, current_module_on_o}, 32'h1);
    chk("refs", {25'h0, ref_voltage_choice_o, ref_resistor_choice_o, trim_o}, 32'h7f);
    wr(8'h5c, 32'h0580_00f0);
    @(posedge ref_clk_i);
    #1;
    chk("sources", {24'h0, discharge_src_en_o}, 32'h05);
    wr(8'h60, 32'hffff_ff03);
    rdc(8'h60, 32'h03, "spread");
    wr(8'h64, 32'hffff_ffff);
    rdc(8'h64, 32'h1_ffff, "pad a");
    chk("idle drive", {15'h0, ohmic_drive_a_o}, 32'h0);
    wr(8'h68, 32'h0000_0005);
    rdc(8'h68, 32'h5, "pad b");
    wr(8'h54, 32'hffff_ffff);
    rdc(8'h54, 32'h0, "count ro");
    for (g = 0; g < 2; g++) begin
      delay_i <= g ? 8'h05 : 8'h00;
      wr(8'h50, 32'(g));
      rdc(8'h50, 32'(g), "select");
      wait_hi(2);
      @(posedge ref_clk_i);
      #1;
      chk("drive a", {15'h0, ohmic_drive_a_o}, 32'h1_ffff);
      chk("drive b", {15'h0, ohmic_drive_b_o}, 32'h5);
      wait_hi(3);
      chk("measure sources", {24'h0, discharge_src_en_o}, 32'hf5);
      for (p = 0; p < 17; p++) begin
        if ((g ? pair_en_b_i[p] : pair_en_a_i[p]) === 1'b1) begin
          wait_hi(1'b0);
          chk("busy", {31'h0, acq_busy_o}, 32'h1);
          chk("index", {24'h0, pair_or_column_index_o}, 32'(p));
          rdc(8'h54, {8'h00, p[7:0], p[7:0], 8'h00}, "self result");
          chk("avail", {31'h0, count_data_avail_o}, 32'h0);
        end
      end
    end
    wr(8'h58, 32'h0202_0202);
    @(posedge ref_clk_i);
    #1;
    chk("stray", {31'h0, burst_values_needed_o}, 32'h0);
    wr(8'h50, 32'h2);
    for (x = 0; x < 8; x++) begin
      if (x_en_i[x] === 1'b1) begin
        wait_hi(1'b1);
        wr(8'h58, 32'h0101_0101);
        @(posedge ref_clk_i);
        #1;
        chk("needed", {31'h0, burst_values_needed_o}, 32'h0);
        for (y = 0; y < 8; y++) begin
          if (y_en_i[y] === 1'b1) begin
            wait_hi(1'b0);
            chk("y index", {24'h0, meas_y_o}, 32'(y));
            rdc(8'h54, {y[7:0], x[7:0], x[7:0], y[7:0]}, "matrix result");
          end
        end
      end
    end
    @(posedge ref_clk_i);
    #1;
    chk("idle", {31'h0, acq_busy_o}, 32'h0);
    final_report();
  end
endmodule
